// [design/adclc_top.sv]
// Converter configuration, limit window and result registers
`timescale 1ns/1ns
`default_nettype none
module adclc_top
   import adclc_pkg::*;
(
   input  wire logic                clk,
   input  wire logic                rst_n,
   input  wire logic [ADDR_W-1:0]   reg_addr,
   input  wire logic [DATA_W-1:0]   reg_wdata,
   input  wire logic                reg_write,
   input  wire logic                reg_read,
   output logic [DATA_W-1:0]        reg_rdata,
   input  wire logic                wake_trigger,
   input  wire logic                sample_valid,
   input  wire logic [SAMPLE_W-1:0] sample_data,
   output logic                     sample_req,
   output logic [CHAN_W:0]          analog_channel,
   output logic [1:0]               plus_ref_select,
   output logic                     minus_ref_select,
   output logic                     resolution_select,
   output logic                     low_power_wake_convert,
   output logic                     conversion_done_irq
);
   ////////////////////////////////////////////////////////////////////////////
   // Software visible state
   logic [7:0]            converter_mode_two;
   logic [7:0]            result_upper_limit;
   logic [7:0]            result_lower_limit;
   logic [7:0]            input_channel_select;
   logic                  channel_mode_select;
   logic [RESULT_W-1:0]   conversion_result;
   logic [7:0]            irq_status;
   logic [7:0]            irq_mask;
   logic                  start_pulse;

   logic                  wr_control;
   logic                  wr_mode_two;
   logic                  rd_status;
   logic                  bad_ref_write;
   logic                  seq_start;
   logic                  seq_busy;
   logic                  seq_done;
   logic [SAMPLE_W-1:0]   seq_sample;
   logic [SAMPLE_W-1:0]   sized_sample;
   logic                  window_hit;
   logic [7:0]            irq_set;
   logic [7:0]            next_irq_status;
   logic [DATA_W-1:0]     next_rdata;

   logic                  wr_upper;
   logic                  wr_lower;
   logic                  wr_channel;
   logic                  wr_mask;

   logic [1:0]            plus_ref_field;
   logic                  minus_ref_field;
   logic                  limit_mode_field;
   logic                  low_power_wake_convert_field;
   logic                  res_field;

   // Unmapped offsets decode to no strobe, so writes there are lost
   assign wr_control    = reg_write && (reg_addr == OFS_CONTROL);
   assign wr_mode_two   = reg_write && (reg_addr == OFS_MODE_TWO);
   assign rd_status     = reg_read && (reg_addr == OFS_IRQ_STATUS);
   assign bad_ref_write = wr_mode_two
                          && (reg_wdata[M2_PLUS_HI_BIT:M2_PLUS_LO_BIT] == PREF_PROHIBITED);

   assign wr_upper      = reg_write && (reg_addr == OFS_UPPER_LIMIT);
   assign wr_lower      = reg_write && (reg_addr == OFS_LOWER_LIMIT);
   assign wr_channel    = reg_write && (reg_addr == OFS_CHANNEL);
   assign wr_mask       = reg_write && (reg_addr == OFS_IRQ_MASK);

   // Named fields keep the bit positions in one place
   assign plus_ref_field   = converter_mode_two[M2_PLUS_HI_BIT:M2_PLUS_LO_BIT];
   assign minus_ref_field  = converter_mode_two[M2_MINUS_BIT];
   assign limit_mode_field = converter_mode_two[M2_LIMIT_BIT];
   assign low_power_wake_convert_field     = converter_mode_two[M2_LOW_POWER_WAKE_CONVERT_BIT];
   assign res_field        = converter_mode_two[M2_RES_BIT];

   ////////////////////////////////////////////////////////////////////////////
   // Mode register two
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         converter_mode_two <= RST_MODE_TWO;
      end else if (wr_mode_two) begin
         converter_mode_two <= reg_wdata & M2_WRITE_MASK;
         // Prohibited plus-reference code keeps the previous source
         if (bad_ref_write) begin
            converter_mode_two[M2_PLUS_HI_BIT:M2_PLUS_LO_BIT] <=
               converter_mode_two[M2_PLUS_HI_BIT:M2_PLUS_LO_BIT];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Limits, channel field and channel mode
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         result_upper_limit <= RST_UPPER_LIMIT;
      end else if (wr_upper) begin
         result_upper_limit <= reg_wdata;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         result_lower_limit <= RST_LOWER_LIMIT;
      end else if (wr_lower) begin
         result_lower_limit <= reg_wdata;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         input_channel_select <= RST_CHANNEL;
      end else if (wr_channel) begin
         input_channel_select <= {3'h0, reg_wdata[CHAN_W-1:0] & CHAN_FIELD_MASK};
      end
   end

   // Channel mode lives in the control register, beside the start bit
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         channel_mode_select <= 1'b0;
      end else if (wr_control) begin
         channel_mode_select <= reg_wdata[CTL_SCAN_BIT];
      end
   end

   // Start bit is self clearing; writes while busy are dropped
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         start_pulse <= 1'b0;
      end else begin
         start_pulse <= wr_control && reg_wdata[CTL_START_BIT] && !seq_busy;
      end
   end

   // Wake trigger only counts while low_power_wake_convert is enabled
   // A start that meets a busy sequencer is dropped, not queued
   assign seq_start = start_pulse
                      || (wake_trigger && low_power_wake_convert_field && !seq_busy);

   ////////////////////////////////////////////////////////////////////////////
   // Conversion path
   adclc_sequencer u_seq (
      .clk          (clk),
      .rst_n        (rst_n),
      .start        (seq_start),
      .scan_mode    (channel_mode_select),
      .base_channel (input_channel_select[CHAN_W-1:0]),
      .sample_valid (sample_valid),
      .sample_data  (sample_data),
      .sample_req   (sample_req),
      .channel      (analog_channel),
      .busy         (seq_busy),
      .done         (seq_done),
      .sample       (seq_sample)
   );

   // 8-bit mode clears the four lowest sample bits, result bits 7:4
   always_comb begin
      sized_sample = seq_sample;
      if (res_field) begin
         sized_sample[RES8_DROP_BITS-1:0] = '0;
      end
   end

   adclc_window_check u_window (
      .sample           (sized_sample),
      .upper_limit      (result_upper_limit),
      .lower_limit      (result_lower_limit),
      .limit_check_mode (limit_mode_field),
      .raise_irq        (window_hit)
   );

   // Every result is stored, inside the window or not
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         conversion_result <= '0;
      end else if (seq_done) begin
         conversion_result <= {sized_sample, {JUSTIFY_SHIFT{1'b0}}};
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Analog front-end controls
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         plus_ref_select        <= PREF_ANALOG_SUPPLY;
         minus_ref_select       <= 1'b0;
         resolution_select      <= 1'b0;
         low_power_wake_convert <= 1'b0;
      end else begin
         plus_ref_select        <= plus_ref_field;
         minus_ref_select       <= minus_ref_field;
         resolution_select      <= res_field;
         low_power_wake_convert <= low_power_wake_convert_field;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Interrupt status, mask and output
   always_comb begin
      irq_set                 = 8'h00;
      irq_set[IRQ_DONE_BIT]   = seq_done && window_hit;
      irq_set[IRQ_BADREF_BIT] = bad_ref_write;
      // A new event in the clearing cycle survives the read
      next_irq_status = (rd_status ? 8'h00 : irq_status) | irq_set;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_status <= 8'h00;
      end else begin
         irq_status <= next_irq_status;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_mask <= RST_IRQ_MASK;
      end else if (wr_mask) begin
         irq_mask <= reg_wdata & IRQ_WRITE_MASK;
      end
   end

   // Registered from next_irq_status, so the pin keeps step with irq_status and stays glitch free
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         conversion_done_irq <= 1'b0;
      end else begin
         conversion_done_irq <= |(next_irq_status & irq_mask);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read data, one cycle after the strobe
   always_comb begin
      next_rdata = 8'h00;
      unique case (reg_addr)
         OFS_CONTROL: begin
            next_rdata[CTL_SCAN_BIT] = channel_mode_select;
            next_rdata[CTL_BUSY_BIT] = seq_busy;
         end
         OFS_MODE_TWO: begin
            next_rdata = converter_mode_two;
         end
         OFS_UPPER_LIMIT: begin
            next_rdata = result_upper_limit;
         end
         OFS_LOWER_LIMIT: begin
            next_rdata = result_lower_limit;
         end
         OFS_CHANNEL: begin
            next_rdata = input_channel_select;
         end
         OFS_RESULT_LO: begin
            next_rdata = conversion_result[7:0];
         end
         OFS_RESULT_HI: begin
            next_rdata = conversion_result[15:8];
         end
         OFS_IRQ_STATUS: begin
            next_rdata = irq_status;
         end
         OFS_IRQ_MASK: begin
            next_rdata = irq_mask;
         end
         // Unmapped offsets read as zero
         default: begin
            next_rdata = 8'h00;
         end
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata <= 8'h00;
      end else if (reg_read) begin
         reg_rdata <= next_rdata;
      end else begin
         reg_rdata <= 8'h00;
      end
   end
endmodule : adclc_top
`default_nettype wire

// [design/adclc_pkg.sv]
// Register map, field layout and encodings of the converter control block
package adclc_pkg;
   localparam int          ADDR_W          = 4;
   localparam int          DATA_W          = 8;
   localparam int          SAMPLE_W        = 12;
   localparam int          RESULT_W        = 16;
   localparam int          CHAN_W          = 5;
   localparam int          GROUP_SIZE      = 4;
   ////////////////////////////////////////////////////////////////////////////
   // Register offsets
   localparam logic [3:0]  OFS_CONTROL     = 4'h0;
   localparam logic [3:0]  OFS_MODE_TWO    = 4'h1;
   localparam logic [3:0]  OFS_UPPER_LIMIT = 4'h2;
   localparam logic [3:0]  OFS_LOWER_LIMIT = 4'h3;
   localparam logic [3:0]  OFS_CHANNEL     = 4'h4;
   localparam logic [3:0]  OFS_RESULT_LO   = 4'h5;
   localparam logic [3:0]  OFS_RESULT_HI   = 4'h6;
   localparam logic [3:0]  OFS_IRQ_STATUS  = 4'h7;
   localparam logic [3:0]  OFS_IRQ_MASK    = 4'h8;
   ////////////////////////////////////////////////////////////////////////////
   // Field positions
   localparam int          CTL_START_BIT   = 0;
   localparam int          CTL_SCAN_BIT    = 1;
   localparam int          CTL_BUSY_BIT    = 7;
   localparam int          M2_PLUS_HI_BIT  = 7;
   localparam int          M2_PLUS_LO_BIT  = 6;
   localparam int          M2_MINUS_BIT    = 5;
   localparam int          M2_LIMIT_BIT    = 3;
   localparam int          M2_LOW_POWER_WAKE_CONVERT_BIT   = 2;
   localparam int          M2_RES_BIT      = 0;
   localparam logic [7:0]  M2_WRITE_MASK   = 8'hED;
   localparam int          IRQ_DONE_BIT    = 0;
   localparam int          IRQ_BADREF_BIT  = 1;
   localparam logic [7:0]  IRQ_WRITE_MASK  = 8'h03;
   localparam logic [4:0]  CHAN_FIELD_MASK = 5'h1F;
   localparam int          RES8_DROP_BITS  = 4;
   localparam int          JUSTIFY_SHIFT   = RESULT_W - SAMPLE_W;
   ////////////////////////////////////////////////////////////////////////////
   // Reset values
   localparam logic [7:0]  RST_MODE_TWO    = 8'h00;
   localparam logic [7:0]  RST_UPPER_LIMIT = 8'hFF;
   localparam logic [7:0]  RST_LOWER_LIMIT = 8'h00;
   localparam logic [7:0]  RST_CHANNEL     = 8'h00;
   localparam logic [7:0]  RST_IRQ_MASK    = 8'h00;
   ////////////////////////////////////////////////////////////////////////////
   // Encodings
   typedef enum logic [1:0] {
      PREF_ANALOG_SUPPLY = 2'h0,
      PREF_EXT_PIN       = 2'h1,
      PREF_INTERNAL      = 2'h2,
      PREF_PROHIBITED    = 2'h3
   } adclc_plus_ref_type;

   typedef enum logic [1:0] {
      SEQ_IDLE = 2'h0,
      SEQ_REQ  = 2'h1,
      SEQ_WAIT = 2'h3,
      SEQ_DONE = 2'h2
   } adclc_seq_state_type;
endpackage : adclc_pkg

// [design/adclc_window_check.sv]
// Upper/lower limit window comparison of a conversion result
`timescale 1ns/1ns
`default_nettype none
module adclc_window_check
   import adclc_pkg::*;
(
   input  wire logic [SAMPLE_W-1:0] sample,
   input  wire logic [7:0]          upper_limit,
   input  wire logic [7:0]          lower_limit,
   input  wire logic                limit_check_mode,
   output logic                     raise_irq
);
   logic [7:0] top_byte;
   logic       inside_window_region;
   logic       below_window_region;
   logic       above_window_region;

   // Only the upper eight result bits meet the 8-bit limits
   assign top_byte             = sample[SAMPLE_W-1 -: 8];
   assign inside_window_region = (top_byte >= lower_limit) && (top_byte <= upper_limit);
   assign below_window_region  = (top_byte <= lower_limit);
   assign above_window_region  = (top_byte > upper_limit);

   always_comb begin
      if (limit_check_mode) begin
         raise_irq = below_window_region || above_window_region;
      end else begin
         raise_irq = inside_window_region;
      end
   end
endmodule : adclc_window_check
`default_nettype wire

// [design/adclc_sequencer.sv]
// Conversion sequencer: select one input or scan a group of four
`timescale 1ns/1ns
`default_nettype none
module adclc_sequencer
   import adclc_pkg::*;
(
   input  wire logic                clk,
   input  wire logic                rst_n,
   input  wire logic                start,
   input  wire logic                scan_mode,
   input  wire logic [CHAN_W-1:0]   base_channel,
   input  wire logic                sample_valid,
   input  wire logic [SAMPLE_W-1:0] sample_data,
   output logic                     sample_req,
   output logic [CHAN_W:0]          channel,
   output logic                     busy,
   output logic                     done,
   output logic [SAMPLE_W-1:0]      sample
);
   adclc_seq_state_type state;
   logic [1:0]          step;
   logic                last_step;

   // Select mode stops after one input, scan after four
   assign last_step = !scan_mode || (step == 2'(GROUP_SIZE - 1));

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= SEQ_IDLE;
         step  <= 2'h0;
      end else begin
         unique case (state)
            SEQ_IDLE: begin
               step <= 2'h0;
               if (start) begin
                  state <= SEQ_REQ;
               end
            end
            SEQ_REQ: begin
               state <= SEQ_WAIT;
            end
            SEQ_WAIT: begin
               if (sample_valid) begin
                  state <= SEQ_DONE;
               end
            end
            SEQ_DONE: begin
               step  <= step + 2'h1;
               state <= last_step ? SEQ_IDLE : SEQ_REQ;
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sample_req <= 1'b0;
         channel    <= '0;
         busy       <= 1'b0;
      end else begin
         sample_req <= (state == SEQ_REQ);
         // Group slides by one input per field step
         channel    <= {1'b0, base_channel} + {4'h0, step};
         busy       <= (state != SEQ_IDLE) || start;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         done   <= 1'b0;
         sample <= '0;
      end else begin
         done <= (state == SEQ_WAIT) && sample_valid;
         if ((state == SEQ_WAIT) && sample_valid) begin
            sample <= sample_data;
         end
      end
   end
endmodule : adclc_sequencer
`default_nettype wire

// [testbench/adclc_properties.sv]
// Port-level properties of the converter control block
`timescale 1ns/1ns
`default_nettype none
module adclc_properties
   import adclc_pkg::*;
(
   input  wire logic                clk,
   input  wire logic                rst_n,
   input  wire logic [ADDR_W-1:0]   reg_addr,
   input  wire logic [DATA_W-1:0]   reg_wdata,
   input  wire logic                reg_write,
   input  wire logic                reg_read,
   input  wire logic [DATA_W-1:0]   reg_rdata,
   input  wire logic                wake_trigger,
   input  wire logic                sample_valid,
   input  wire logic [SAMPLE_W-1:0] sample_data,
   input  wire logic                sample_req,
   input  wire logic [CHAN_W:0]     analog_channel,
   input  wire logic [1:0]          plus_ref_select,
   input  wire logic                minus_ref_select,
   input  wire logic                resolution_select,
   input  wire logic                low_power_wake_convert,
   input  wire logic                conversion_done_irq
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   logic                            m2w;
   // Two-edge look ahead matches the two-stage output path: mode register, then output flop
   assign m2w = reg_write && reg_addr == OFS_MODE_TWO;
   ////////////////////////////////////////
   property p_ref_legal;
      plus_ref_select != 2'h3;
   endproperty
   a_ref_legal: assert property (p_ref_legal) else $error("prohibited plus ref");
   property p_plus_ref;
      m2w && reg_wdata[7:6] != 2'h3 |-> ##2 plus_ref_select == $past(reg_wdata[7:6], 2);
   endproperty
   a_plus_ref: assert property (p_plus_ref) else $error("plus ref not taken");
   property p_minus_ref;
      m2w |-> ##2 minus_ref_select == $past(reg_wdata[M2_MINUS_BIT], 2);
   endproperty
   a_minus_ref: assert property (p_minus_ref) else $error("minus ref not taken");
   property p_low_power_wake_convert;
      m2w |-> ##2 low_power_wake_convert == $past(reg_wdata[M2_LOW_POWER_WAKE_CONVERT_BIT], 2);
   endproperty
   a_low_power_wake_convert: assert property (p_low_power_wake_convert) else $error("low_power_wake_convert enable not taken");
   property p_res;
      m2w |-> ##2 resolution_select == $past(reg_wdata[M2_RES_BIT], 2);
   endproperty
   a_res: assert property (p_res) else $error("resolution not taken");
   property p_wake_off;
      wake_trigger && !low_power_wake_convert |=> !sample_req [*4];
   endproperty
   a_wake_off: assert property (p_wake_off) else $error("wake start while off");
   property p_req_pulse;
      sample_req |=> !sample_req;
   endproperty
   a_req_pulse: assert property (p_req_pulse) else $error("request too long");
   property p_chan_stable;
      sample_req |=> $stable(analog_channel);
   endproperty
   a_chan_stable: assert property (p_chan_stable) else $error("channel moved");
   property p_start_req;
      reg_write && reg_addr == OFS_CONTROL && reg_wdata[CTL_START_BIT] |-> ##3 sample_req;
   endproperty
   a_start_req: assert property (p_start_req) else $error("no request after start");
   property p_irq_cause;
      $rose(conversion_done_irq) |->
         $past(sample_valid, 2) || $past(sample_valid, 3) || $past(reg_write) || $past(reg_write, 2);
   endproperty
   a_irq_cause: assert property (p_irq_cause) else $error("irq without cause");
   property p_rdata_idle;
      !$past(reg_read) |-> reg_rdata == 8'h00;
   endproperty
   a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside slot");
   c_irq: cover property ($rose(conversion_done_irq));
   c_top_chan: cover property (sample_req && analog_channel == 6'h22);
   c_wake: cover property (wake_trigger && low_power_wake_convert);
endmodule : adclc_properties
bind adclc_top adclc_properties i_adclc_properties (.*);
`default_nettype wire

// [testbench/adclc_front_end.sv]
// Analog front end model answering conversion requests
`timescale 1ns/1ns
`default_nettype none
module adclc_front_end
   import adclc_pkg::*;
(
   input  wire logic                clk,
   input  wire logic                rst_n,
   input  wire logic                sample_req,
   input  wire logic [CHAN_W:0]     analog_channel,
   input  wire logic [SAMPLE_W-1:0] base_value,
   input  wire logic [3:0]          delay,
   output logic                     sample_valid,
   output logic [SAMPLE_W-1:0]      sample_data
);
   logic [4:0]                      wait_cnt;
   // Idle data toggles so a stale value is never read as fresh
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wait_cnt     <= 5'h00;
         sample_valid <= 1'b0;
         sample_data  <= 12'h000;
      end else begin
         sample_valid <= 1'b0;
         sample_data  <= ~sample_data;
         if (sample_req) begin
            wait_cnt <= {1'b0, delay} + 5'h01;
         end else if (wait_cnt == 5'h01) begin
            wait_cnt     <= 5'h00;
            sample_valid <= 1'b1;
            sample_data  <= base_value + {2'h0, analog_channel, 4'h0};
         end else if (wait_cnt != 5'h00) begin
            wait_cnt <= wait_cnt - 5'h01;
         end
      end
   end
endmodule : adclc_front_end
`default_nettype wire

// [testbench/adclc_top_test.sv]
// Self-checking bench of the converter control block
`timescale 1ns/1ns
`default_nettype none
module adclc_top_test;
   import adclc_pkg::*;
   logic                clk;
   logic                rst_n;
   logic [ADDR_W-1:0]   reg_addr;
   logic [DATA_W-1:0]   reg_wdata;
   logic                reg_write;
   logic                reg_read;
   logic [DATA_W-1:0]   reg_rdata;
   logic                wake_trigger;
   logic                sample_valid;
   logic [SAMPLE_W-1:0] sample_data;
   logic                sample_req;
   logic [CHAN_W:0]     analog_channel;
   logic [1:0]          plus_ref_select;
   logic                minus_ref_select;
   logic                resolution_select;
   logic                low_power_wake_convert;
   logic                conversion_done_irq;
   logic [SAMPLE_W-1:0] base_value;
   logic [3:0]          delay;
   logic [CHAN_W:0]     chans[$];
   int                  num_errors;
   int                  checks_done;
   adclc_top i_adclc_top (.*);
   adclc_front_end i_adclc_front_end (.*);
   always @(posedge clk) begin
      if (sample_req === 1'b1) begin
         chans.push_back(analog_channel);
      end
   end
   ////////////////////////////////////////
   task automatic test_done;
      $display("checks %0d errors %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : test_done
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      checks_done++;
      if (got !== exp) begin
         num_errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge clk);
      reg_write <= 1'b0;
   endtask : wr
   task automatic rdck(input logic [3:0] a, input logic [7:0] exp);
      @(posedge clk);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge clk);
      reg_read <= 1'b0;
      #1 check(reg_rdata, exp);
   endtask : rdck
   // Polls busy with a bound so a stuck sequencer cannot hang the run
   task automatic run(input logic [7:0] ctl);
      int n;
      logic [7:0] st;
      wr(OFS_CONTROL, ctl);
      st = 8'h80;
      for (n = 0; n < 60 && st[CTL_BUSY_BIT] !== 1'b0; n++) begin
         @(posedge clk);
         reg_addr <= OFS_CONTROL;
         reg_read <= 1'b1;
         @(posedge clk);
         reg_read <= 1'b0;
         #1 st = reg_rdata;
      end
      check(n < 60, 1'b1);
   endtask : run
   ////////////////////////////////////////
   task automatic t_regs;
      rdck(OFS_MODE_TWO, 8'h00);
      rdck(OFS_UPPER_LIMIT, 8'hFF);
      rdck(OFS_LOWER_LIMIT, 8'h00);
      rdck(OFS_CHANNEL, 8'h00);
      rdck(OFS_IRQ_MASK, 8'h00);
      wr(4'hF, 8'h77);
      rdck(4'hF, 8'h00);
      wr(OFS_UPPER_LIMIT, 8'hA5);
      wr(OFS_LOWER_LIMIT, 8'h5A);
      rdck(OFS_UPPER_LIMIT, 8'hA5);
      rdck(OFS_LOWER_LIMIT, 8'h5A);
   endtask : t_regs
   task automatic t_mode;
      logic [7:0] d;
      for (int p = 0; p < 3; p++) begin
         d = {p[1:0], p[0], 1'b1, p[1], ~p[0], 1'b1, ~p[1]};
         wr(OFS_MODE_TWO, d);
         rdck(OFS_MODE_TWO, d & 8'hED);
         check(plus_ref_select, p[1:0]);
         check(minus_ref_select, d[5]);
         check(low_power_wake_convert, d[2]);
         check(resolution_select, d[0]);
      end
      wr(OFS_IRQ_MASK, 8'h03);
      wr(OFS_MODE_TWO, 8'hC0);
      rdck(OFS_MODE_TWO, 8'h80);
      check(conversion_done_irq, 1'b1);
      rdck(OFS_IRQ_STATUS, 8'h02);
      check(conversion_done_irq, 1'b0);
   endtask : t_mode
   task automatic t_window;
      logic [16:0] tbl[8] = '{17'h18040, 17'h18080, 17'h0803F, 17'h08081,
                              17'h18140, 17'h08141, 17'h08180, 17'h18181};
      wr(OFS_UPPER_LIMIT, 8'h80);
      wr(OFS_LOWER_LIMIT, 8'h40);
      for (int i = 0; i < 8; i++) begin
         wr(OFS_MODE_TWO, {4'h0, tbl[i][8], 3'h0});
         base_value <= {tbl[i][7:0], 4'h9};
         delay      <= i[3:0];
         run(8'h01);
         check(conversion_done_irq, tbl[i][16]);
         rdck(OFS_RESULT_HI, tbl[i][7:0]);
         rdck(OFS_RESULT_LO, 8'h90);
         rdck(OFS_IRQ_STATUS, {7'h0, tbl[i][16]});
      end
   endtask : t_window
   task automatic t_res8;
      wr(OFS_MODE_TWO, 8'h01);
      base_value <= 12'hABC;
      chans.delete();
      run(8'h01);
      check(chans.size(), 1);
      rdck(OFS_RESULT_HI, 8'hAB);
      rdck(OFS_RESULT_LO, 8'h00);
   endtask : t_res8
   task automatic t_scan;
      logic [4:0] b[2] = '{5'h05, 5'h1F};
      wr(OFS_MODE_TWO, 8'h00);
      base_value <= 12'h100;
      for (int j = 0; j < 2; j++) begin
         wr(OFS_CHANNEL, {3'h0, b[j]});
         chans.delete();
         run(8'h03);
         check(chans.size(), 4);
         for (int k = 0; k < 4 && k < chans.size(); k++) begin
            check(chans[k], {1'b0, b[j]} + k[5:0]);
         end
         rdck(OFS_RESULT_HI, 8'h13 + {3'h0, b[j]});
         rdck(OFS_IRQ_STATUS, 8'h00);
      end
   endtask : t_scan
   task automatic t_wake;
      wr(OFS_CONTROL, 8'h00);
      for (int s = 0; s < 2; s++) begin
         wr(OFS_MODE_TWO, {5'h0, s[0], 2'h0});
         chans.delete();
         @(posedge clk);
         wake_trigger <= 1'b1;
         @(posedge clk);
         wake_trigger <= 1'b0;
         repeat (20) @(posedge clk);
         check(chans.size(), s);
      end
   endtask : t_wake
   ////////////////////////////////////////
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   initial begin
      repeat (20000) @(posedge clk);
      num_errors++;
      test_done;
   end
   initial begin
      rst_n        = 1'b0;
      reg_addr     = 4'h0;
      reg_wdata    = 8'h00;
      reg_write    = 1'b0;
      reg_read     = 1'b0;
      wake_trigger = 1'b0;
      base_value   = 12'h000;
      delay        = 4'h0;
      num_errors   = 0;
      checks_done  = 0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      t_regs;
      t_mode;
      t_window;
      t_res8;
      t_scan;
      t_wake;
      test_done;
   end
endmodule : adclc_top_test
`default_nettype wire
